// [hdl/dsoc_consts.vh]
// Constants for the drive stop option control block
`ifndef DSOC_CONSTS_VH
`define DSOC_CONSTS_VH

// Object dictionary indexes and sub-indexes
`define DSOC_IDX_QS_DECEL      16'h604A
`define DSOC_SUB_QS_SPEED      8'h01
`define DSOC_SUB_QS_TIME       8'h02
`define DSOC_IDX_QS_CODE       16'h605A
`define DSOC_IDX_SD_CODE       16'h605B
`define DSOC_IDX_DO_CODE       16'h605C
`define DSOC_SUB_ZERO          8'h00

// Reset values
`define DSOC_RST_QS_TIME       16'h0001
`define DSOC_RST_QS_CODE       16'h0006
`define DSOC_RST_SD_CODE       16'h0000
`define DSOC_RST_DO_CODE       16'h0001

// Range limits
`define DSOC_MIN_SPEED         32'h0000_0001
`define DSOC_MIN_TIME          16'h0001

// Option codes
`define DSOC_CODE_DISABLE      16'h0000
`define DSOC_CODE_SLOW_DIS     16'h0001
`define DSOC_CODE_QUICK_DIS    16'h0002
`define DSOC_CODE_SLOW_STAY    16'h0005
`define DSOC_CODE_QUICK_STAY   16'h0006

// Stop actions
`define DSOC_ACT_NONE          2'h0
`define DSOC_ACT_DISABLE       2'h1
`define DSOC_ACT_SLOW_RAMP     2'h2
`define DSOC_ACT_QUICK_RAMP    2'h3

`endif

// [hdl/dsoc_code_reg.v]
// One option code register with a value filter and a reset default
`timescale 1ns/100ps
`include "dsoc_consts.vh"
module dsoc_code_reg #(
  parameter [15:0] RESET_VALUE = 16'h0000,
  parameter [15:0] MAX_VALID   = `DSOC_CODE_SLOW_DIS,
  parameter        ALLOW_FIVE  = 0
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        write_en,
  input  wire [15:0] write_data,
  output reg  [15:0] code,
  output wire        accepted
);

  wire [15:0] max_code;
  wire        stay_code;

  assign max_code  = MAX_VALID;
  assign stay_code = (ALLOW_FIVE != 0) &&
                     ((write_data == `DSOC_CODE_SLOW_STAY) ||
                      (write_data == `DSOC_CODE_QUICK_STAY));
  // Negative, unsupported and reserved codes are refused
  assign accepted = (write_data[15] == 1'b0) &&
                    ((write_data <= max_code) || stay_code); // RQ6

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code <= RESET_VALUE;
    end else if (write_en && accepted) begin
      code <= write_data;
    end
  end

endmodule

// [hdl/dsoc_action_map.v]
// Maps an option code to the stop action and the end behaviour
`timescale 1ns/100ps
`include "dsoc_consts.vh"
module dsoc_action_map (
  input  wire [15:0] code,
  output reg  [1:0]  action,
  output reg         stay
);

  always @* begin
    action = `DSOC_ACT_NONE;
    stay   = 1'b0;
    case (code)
      `DSOC_CODE_DISABLE: begin
        action = `DSOC_ACT_DISABLE; // RQ3
      end
      `DSOC_CODE_SLOW_DIS: begin
        action = `DSOC_ACT_SLOW_RAMP; // RQ4
      end
      `DSOC_CODE_QUICK_DIS: begin
        action = `DSOC_ACT_QUICK_RAMP; // RQ4
      end
      `DSOC_CODE_SLOW_STAY: begin
        action = `DSOC_ACT_SLOW_RAMP; // RQ5
        stay   = 1'b1;
      end
      `DSOC_CODE_QUICK_STAY: begin
        action = `DSOC_ACT_QUICK_RAMP; // RQ5
        stay   = 1'b1;
      end
      default: begin
        action = `DSOC_ACT_NONE;
      end
    endcase
  end

endmodule

// [hdl/dsoc_top.v]
// Drive stop option control: dictionary entries and stop selection
//
// Functional notes
// RQ1 - Quick-stop delta speed, 32-bit, range 1 to motor max, defaults max.
// RQ2 - Quick-stop delta time, 16-bit seconds, range 1 to 65535, default 1.
// RQ3 - Quick-stop code, signed 16-bit, default 6; code 0 disables at once.
// RQ4 - Quick-stop 1: slow-down ramp then disable; 2: quick ramp then disable.
// RQ5 - Quick-stop 5 and 6: ramp then remain in quick-stop state.
// RQ6 - Writes of unsupported or reserved codes refused; old code kept.
// RQ7 - Shutdown code used leaving operation enabled downward; default 0.
// RQ8 - Shutdown 0 disables at once; 1 slow ramp then disable; 2 reserved.
// RQ9 - Disable-operation code used going to switched on; default 1.
// RQ10 - Disable-op 0 disables at once; 1 slow ramp first; 2 reserved.
`timescale 1ns/100ps
`include "dsoc_consts.vh"
module dsoc_top #(
  parameter [31:0] MOTOR_MAX_SPEED = 32'h0000_0BB8
) (
  input  wire        clk,
  input  wire        reset_n,
  input  wire        od_write,
  input  wire        od_read,
  input  wire [15:0] od_index,
  input  wire [7:0]  od_subindex,
  input  wire [31:0] od_wdata,
  output reg  [31:0] od_rdata,
  output reg         od_ack,
  output reg         od_error,
  input  wire        quick_stop_cmd,
  input  wire        shutdown_cmd,
  input  wire        disable_op_cmd,
  input  wire        ramp_done,
  output reg  [1:0]  stop_action,
  output reg         stop_stay,
  output reg         stop_valid,
  output wire [31:0] quickstop_decel_delta_speed,
  output wire [15:0] quickstop_decel_delta_time,
  output wire [15:0] quickstop_reaction_code
);

  ////////////////////////////////////////////////////////////////////////
  // Address decode

  reg  [31:0] speed_reg;
  reg  [15:0] time_reg;
  wire [15:0] shutdown_reaction_code;
  wire [15:0] disable_op_reaction_code;
  wire        od_req;
  wire        idx_decel;
  wire        idx_qs;
  wire        idx_sd;
  wire        idx_do;
  wire        sub_zero;
  reg         hit_speed;
  reg         hit_time;
  reg         hit_qs;
  reg         hit_sd;
  reg         hit_do;
  wire        speed_ok;
  wire        time_ok;
  wire        qs_ok;
  wire        sd_ok;
  wire        do_ok;
  wire        sext_ok;
  wire        wr_speed_en;
  wire        wr_time_en;
  wire        wr_qs_en;
  wire        wr_sd_en;
  wire        wr_do_en;

  assign od_req    = od_write || od_read;
  assign idx_decel = (od_index == `DSOC_IDX_QS_DECEL);
  assign idx_qs    = (od_index == `DSOC_IDX_QS_CODE);
  assign idx_sd    = (od_index == `DSOC_IDX_SD_CODE);
  assign idx_do    = (od_index == `DSOC_IDX_DO_CODE);
  assign sub_zero  = (od_subindex == `DSOC_SUB_ZERO);

  always @* begin
    hit_speed = 1'b0;
    hit_time  = 1'b0;
    hit_qs    = 1'b0;
    hit_sd    = 1'b0;
    hit_do    = 1'b0;
    if (idx_decel && od_subindex == `DSOC_SUB_QS_SPEED) begin
      hit_speed = 1'b1;
    end else if (idx_decel && od_subindex == `DSOC_SUB_QS_TIME) begin
      hit_time = 1'b1;
    end else if (idx_qs && sub_zero) begin
      hit_qs = 1'b1;
    end else if (idx_sd && sub_zero) begin
      hit_sd = 1'b1;
    end else if (idx_do && sub_zero) begin
      hit_do = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Write enables

  // A code word whose upper half is no sign extension never lands
  assign sext_ok     = (od_wdata[31:16] == {16{od_wdata[15]}});
  assign wr_speed_en = od_write && hit_speed;
  assign wr_time_en  = od_write && hit_time;
  assign wr_qs_en    = od_write && hit_qs && sext_ok;
  assign wr_sd_en    = od_write && hit_sd && sext_ok;
  assign wr_do_en    = od_write && hit_do && sext_ok;

  ////////////////////////////////////////////////////////////////////////
  // Ramp pair storage

  assign speed_ok = (od_wdata >= `DSOC_MIN_SPEED) &&
                    (od_wdata <= MOTOR_MAX_SPEED); // RQ1
  assign time_ok  = (od_wdata[15:0] >= `DSOC_MIN_TIME) &&
                    (od_wdata[31:16] == 16'h0000); // RQ2

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      speed_reg <= MOTOR_MAX_SPEED; // RQ1
      time_reg  <= `DSOC_RST_QS_TIME; // RQ2
    end else begin
      if (wr_speed_en && speed_ok) begin
        speed_reg <= od_wdata; // RQ1
      end
      if (wr_time_en && time_ok) begin
        time_reg <= od_wdata[15:0]; // RQ2
      end
    end
  end

  assign quickstop_decel_delta_speed = speed_reg;
  assign quickstop_decel_delta_time  = time_reg;

  ////////////////////////////////////////////////////////////////////////
  // Option code registers

  // Quick stop accepts 0..2 and 5..6
  dsoc_code_reg #(
    .RESET_VALUE (`DSOC_RST_QS_CODE),
    .MAX_VALID   (`DSOC_CODE_QUICK_DIS),
    .ALLOW_FIVE  (1)
  ) u_qs_code (
    .clk        (clk),
    .reset_n    (reset_n),
    .write_en   (wr_qs_en),
    .write_data (od_wdata[15:0]),
    .code       (quickstop_reaction_code),
    .accepted   (qs_ok)
  ); // RQ3

  dsoc_code_reg #(
    .RESET_VALUE (`DSOC_RST_SD_CODE),
    .MAX_VALID   (`DSOC_CODE_SLOW_DIS),
    .ALLOW_FIVE  (0)
  ) u_sd_code (
    .clk        (clk),
    .reset_n    (reset_n),
    .write_en   (wr_sd_en),
    .write_data (od_wdata[15:0]),
    .code       (shutdown_reaction_code),
    .accepted   (sd_ok)
  ); // RQ7

  dsoc_code_reg #(
    .RESET_VALUE (`DSOC_RST_DO_CODE),
    .MAX_VALID   (`DSOC_CODE_SLOW_DIS),
    .ALLOW_FIVE  (0)
  ) u_do_code (
    .clk        (clk),
    .reset_n    (reset_n),
    .write_en   (wr_do_en),
    .write_data (od_wdata[15:0]),
    .code       (disable_op_reaction_code),
    .accepted   (do_ok)
  ); // RQ9

  ////////////////////////////////////////////////////////////////////////
  // Access answer, one cycle after the request

  reg         next_error;
  reg  [31:0] next_rdata;
  wire [31:0] qs_code_ext;
  wire [31:0] sd_code_ext;
  wire [31:0] do_code_ext;

  // Codes read back sign-extended, the form in which they are written
  assign qs_code_ext = {{16{quickstop_reaction_code[15]}},
                        quickstop_reaction_code};
  assign sd_code_ext = {{16{shutdown_reaction_code[15]}},
                        shutdown_reaction_code};
  assign do_code_ext = {{16{disable_op_reaction_code[15]}},
                        disable_op_reaction_code};

  // Refused writes keep the stored value and only raise od_error
  always @* begin
    next_error = 1'b0;
    next_rdata = od_rdata;
    if (hit_speed) begin
      next_rdata = speed_reg;
      next_error = od_write && !speed_ok;
    end else if (hit_time) begin
      next_rdata = {16'h0000, time_reg};
      next_error = od_write && !time_ok;
    end else if (hit_qs) begin
      next_rdata = qs_code_ext;
      next_error = od_write && !(qs_ok && sext_ok); // RQ6
    end else if (hit_sd) begin
      next_rdata = sd_code_ext;
      next_error = od_write && !(sd_ok && sext_ok); // RQ6
    end else if (hit_do) begin
      next_rdata = do_code_ext;
      next_error = od_write && !(do_ok && sext_ok); // RQ6
    end else begin
      next_rdata = 32'h0000_0000;
      next_error = 1'b1;
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      od_rdata <= 32'h0000_0000;
      od_ack   <= 1'b0;
      od_error <= 1'b0;
    end else begin
      od_ack <= od_req;
      // Read data holds until the next read; a write leaves it alone
      if (od_req) begin
        od_error <= next_error;
        if (od_read) begin
          od_rdata <= next_rdata;
        end
      end else begin
        od_error <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Stop selection

  wire [1:0] qs_action;
  wire       qs_stay;
  wire [1:0] sd_action;
  wire [1:0] do_action;
  reg  [1:0] next_action;
  reg        next_stay;
  reg        next_valid;
  wire       in_ramp;
  wire       ramp_ends;

  dsoc_action_map u_qs_map (
    .code   (quickstop_reaction_code),
    .action (qs_action),
    .stay   (qs_stay)
  );

  dsoc_action_map u_sd_map (
    .code   (shutdown_reaction_code),
    .action (sd_action),
    .stay   ()
  );

  dsoc_action_map u_do_map (
    .code   (disable_op_reaction_code),
    .action (do_action),
    .stay   ()
  );

  // Stay codes keep their ramp; leaving quick stop is up to the drive
  assign in_ramp   = (stop_action == `DSOC_ACT_SLOW_RAMP) ||
                     (stop_action == `DSOC_ACT_QUICK_RAMP);
  assign ramp_ends = stop_valid && ramp_done && !stop_stay && in_ramp;

  // Quick stop has priority; a ramp ends in disable unless told to stay
  always @* begin
    next_action = stop_action;
    next_stay   = stop_stay;
    next_valid  = stop_valid;
    if (quick_stop_cmd) begin
      next_action = qs_action; // RQ3
      next_stay   = qs_stay; // RQ5
      next_valid  = 1'b1;
    end else if (shutdown_cmd) begin
      next_action = sd_action; // RQ8
      next_stay   = 1'b0;
      next_valid  = 1'b1; // RQ7
    end else if (disable_op_cmd) begin
      next_action = do_action; // RQ10
      next_stay   = 1'b0;
      next_valid  = 1'b1; // RQ9
    end else if (ramp_ends) begin
      next_action = `DSOC_ACT_DISABLE; // RQ4
    end
  end

  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stop_action <= `DSOC_ACT_NONE;
      stop_stay   <= 1'b0;
      stop_valid  <= 1'b0;
    end else begin
      stop_action <= next_action;
      stop_stay   <= next_stay;
      stop_valid  <= next_valid;
    end
  end

endmodule

// [testbench/dsoc_sva.sv]
// Checker for the stop option control block
`timescale 1ns/100ps
module dsoc_sva #(
  parameter [31:0] MOTOR_MAX_SPEED = 32'h0000_0BB8
) (
  input wire        clk,
  input wire        reset_n,
  input wire        od_write,
  input wire        od_read,
  input wire [15:0] od_index,
  input wire [7:0]  od_subindex,
  input wire [31:0] od_wdata,
  input wire        od_ack,
  input wire        od_error,
  input wire        quick_stop_cmd,
  input wire        shutdown_cmd,
  input wire        disable_op_cmd,
  input wire        ramp_done,
  input wire [1:0]  stop_action,
  input wire        stop_stay,
  input wire [31:0] quickstop_decel_delta_speed,
  input wire [15:0] quickstop_decel_delta_time,
  input wire [15:0] quickstop_reaction_code
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire [15:0] qc = quickstop_reaction_code;
  wire no_cmd = !quick_stop_cmd && !shutdown_cmd && !disable_op_cmd;
  sequence qs_wr;
    od_write && od_index == 16'h605A && od_subindex == 8'h00;
  endsequence
  sequence ramp_hold;
    stop_stay && ramp_done && no_cmd;
  endsequence
  sequence qs_wr_bad;
    qs_wr ##0 (od_wdata == 32'h3 || od_wdata == 32'h4 || od_wdata == 32'h7);
  endsequence
  ack_latency_a: assert property (od_write || od_read |=> od_ack)
    else $error("access not acknowledged");
  speed_range_a: assert property (quickstop_decel_delta_speed != 32'h0 &&
    quickstop_decel_delta_speed <= MOTOR_MAX_SPEED)
    else $error("speed out of range");
  time_range_a: assert property (quickstop_decel_delta_time != 16'h0)
    else $error("time is zero");
  qs_legal_a: assert property (qc <= 16'h2 || qc == 16'h5 || qc == 16'h6)
    else $error("illegal quick stop code stored");
  qs_store_a: assert property (qs_wr ##0 od_wdata == 32'h5 |=>
    qc == 16'h5 && !od_error) else $error("code 5 not stored");
  qs_refuse_a: assert property (qs_wr_bad |=> $stable(qc) && od_error)
    else $error("bad code not refused");
  qs_disable_a: assert property (quick_stop_cmd && qc == 16'h0 |=>
    stop_action == 2'h1 && !stop_stay) else $error("code 0 action");
  qs_stay_a: assert property (quick_stop_cmd && qc == 16'h6 |=>
    stop_action == 2'h3 && stop_stay) else $error("code 6 action");
  ramp_end_a: assert property (stop_action == 2'h3 && !stop_stay &&
    ramp_done && no_cmd |=> stop_action == 2'h1)
    else $error("no disable after ramp");
  sd_action_a: assert property (shutdown_cmd && !quick_stop_cmd |=>
    (stop_action == 2'h1 || stop_action == 2'h2) && !stop_stay)
    else $error("shutdown action");
  do_action_a: assert property (disable_op_cmd && !quick_stop_cmd &&
    !shutdown_cmd |=> (stop_action == 2'h1 || stop_action == 2'h2))
    else $error("disable operation action");
  ramp_stay_a: assert property (ramp_hold |=> $stable(stop_action))
    else $error("stay code left its ramp");
endmodule
bind dsoc_top dsoc_sva #(.MOTOR_MAX_SPEED(MOTOR_MAX_SPEED)) dsoc_sva_inst (
  .clk                         (clk),
  .reset_n                     (reset_n),
  .od_write                    (od_write),
  .od_read                     (od_read),
  .od_index                    (od_index),
  .od_subindex                 (od_subindex),
  .od_wdata                    (od_wdata),
  .od_ack                      (od_ack),
  .od_error                    (od_error),
  .quick_stop_cmd              (quick_stop_cmd),
  .shutdown_cmd                (shutdown_cmd),
  .disable_op_cmd              (disable_op_cmd),
  .ramp_done                   (ramp_done),
  .stop_action                 (stop_action),
  .stop_stay                   (stop_stay),
  .quickstop_decel_delta_speed (quickstop_decel_delta_speed),
  .quickstop_decel_delta_time  (quickstop_decel_delta_time),
  .quickstop_reaction_code     (quickstop_reaction_code)
);

// [testbench/dsoc_master_model.sv]
// Fieldbus master model issuing dictionary accesses
`timescale 1ns/100ps
module dsoc_master_model (
  input  wire        clk,
  input  wire [31:0] od_rdata,
  input  wire        od_ack,
  input  wire        od_error,
  output reg         od_write,
  output reg         od_read,
  output reg  [15:0] od_index,
  output reg  [7:0]  od_subindex,
  output reg  [31:0] od_wdata
);
  initial begin
    od_write = 1'b0;
    od_read = 1'b0;
    od_index = 16'h0000;
    od_subindex = 8'h00;
    od_wdata = 32'h0000_0000;
  end
  // Missing ack turns the error flag unknown so the caller sees it
  task access(input w, input [15:0] i, input [7:0] s, input [31:0] d,
              output [31:0] rd, output e);
    begin
      @(posedge clk);
      od_write <= w;
      od_read <= !w;
      od_index <= i;
      od_subindex <= s;
      od_wdata <= w ? d : ~d;
      @(posedge clk);
      od_write <= 1'b0;
      od_read <= 1'b0;
      od_wdata <= ~d;
      #1;
      rd = od_rdata;
      e = (od_ack === 1'b1) ? od_error : 1'bx;
    end
  endtask
endmodule

// [testbench/tb_drive_stop_option_control.sv]
// Self-checking bench for the stop option control block
`timescale 1ns/100ps
module tb_drive_stop_option_control;
  localparam [31:0] MAXS = 32'h0000_0064;
  reg clk = 1'b0, reset_n = 1'b0, qs = 1'b0, sd = 1'b0, dop = 1'b0;
  reg ramp_done = 1'b0;
  wire od_write, od_read, od_ack, od_error, stop_stay, stop_valid;
  wire [15:0] od_index, tm, qc;
  wire [7:0] od_subindex;
  wire [31:0] od_wdata, od_rdata, sp;
  wire [1:0] stop_action;
  integer bad_count = 0, check_count = 0;
  always #10 clk = ~clk;
  dsoc_top #(.MOTOR_MAX_SPEED(MAXS)) dsoc_top_inst (.clk(clk),
    .reset_n(reset_n), .od_write(od_write), .od_read(od_read),
    .od_index(od_index), .od_subindex(od_subindex), .od_wdata(od_wdata),
    .od_rdata(od_rdata), .od_ack(od_ack), .od_error(od_error),
    .quick_stop_cmd(qs), .shutdown_cmd(sd), .disable_op_cmd(dop),
    .ramp_done(ramp_done), .stop_action(stop_action), .stop_stay(stop_stay),
    .stop_valid(stop_valid), .quickstop_decel_delta_speed(sp),
    .quickstop_decel_delta_time(tm), .quickstop_reaction_code(qc));
  dsoc_master_model dsoc_master_model_inst (.clk(clk), .od_rdata(od_rdata),
    .od_ack(od_ack), .od_error(od_error), .od_write(od_write),
    .od_read(od_read), .od_index(od_index), .od_subindex(od_subindex),
    .od_wdata(od_wdata));
  task chk(input [31:0] g, input [31:0] e);
    begin
      check_count = check_count + 1;
      if (g !== e) begin
        bad_count = bad_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
    end
  endtask
  // For reads d is the expected data
  task acc(input w, input [15:0] i, input [7:0] s, input [31:0] d,
           input e);
    reg [31:0] rd;
    reg        er;
    begin
      dsoc_master_model_inst.access(w, i, s, d, rd, er);
      chk({31'h0, er}, {31'h0, e});
      if (!w) chk(rd, d);
    end
  endtask
  task pulse(input [2:0] c, input [2:0] exp);
    begin
      @(posedge clk);
      {qs, sd, dop} <= c;
      @(posedge clk);
      {qs, sd, dop} <= 3'b000;
      #1;
      chk({stop_stay, stop_action}, exp);
    end
  endtask
  task ramp(input [2:0] exp);
    begin
      @(posedge clk);
      ramp_done <= 1'b1;
      @(posedge clk);
      ramp_done <= 1'b0;
      #1;
      chk({stop_stay, stop_action}, exp);
    end
  endtask
  function [2:0] qs_exp(input [15:0] c);
    case (c)
      16'h0000: qs_exp = 3'b001;
      16'h0001: qs_exp = 3'b010;
      16'h0002: qs_exp = 3'b011;
      16'h0005: qs_exp = 3'b110;
      default:  qs_exp = 3'b111;
    endcase
  endfunction
  task t_defaults;
    begin
      chk(stop_valid, 0);
      acc(0, 16'h604A, 8'h01, MAXS, 0);
      acc(0, 16'h604A, 8'h02, 32'h1, 0);
      acc(0, 16'h605A, 8'h00, 32'h6, 0);
      acc(0, 16'h605B, 8'h00, 32'h0, 0);
      acc(0, 16'h605C, 8'h00, 32'h1, 0);
      $display("defaults done");
    end
  endtask
  task t_qs_codes;
    integer k;
    reg     ok;
    reg [15:0] cur;
    begin
      cur = 16'h0006;
      for (k = 0; k < 8; k = k + 1) begin
        ok = (k < 3) || (k == 5) || (k == 6);
        acc(1, 16'h605A, 8'h00, k, !ok);
        if (ok) cur = k;
        chk(qc, cur);
        pulse(3'b100, qs_exp(cur));
      end
      ramp(3'b111);
      acc(1, 16'h605A, 8'h00, 32'hFFFF_FFFF, 1);
      acc(1, 16'h605A, 8'h00, 32'h0001_0002, 1);
      chk(qc, 16'h0006);
      chk(stop_valid, 1);
      acc(1, 16'h605A, 8'h00, 32'h2, 0);
      pulse(3'b100, 3'b011);
      ramp(3'b001);
      pulse(3'b111, 3'b011);
      $display("quick stop codes done");
    end
  endtask
  task t_shut_dis;
    begin
      pulse(3'b010, 3'b001);
      acc(1, 16'h605B, 8'h00, 32'h1, 0);
      acc(1, 16'h605B, 8'h00, 32'h2, 1);
      pulse(3'b011, 3'b010);
      ramp(3'b001);
      pulse(3'b001, 3'b010);
      acc(1, 16'h605C, 8'h00, 32'h0, 0);
      acc(1, 16'h605C, 8'h00, 32'h2, 1);
      pulse(3'b001, 3'b001);
      $display("shutdown and disable done");
    end
  endtask
  task t_ranges;
    begin
      acc(1, 16'h604A, 8'h01, 32'h0, 1);
      acc(1, 16'h604A, 8'h01, MAXS + 1, 1);
      acc(1, 16'h604A, 8'h01, 32'h1, 0);
      chk(sp, 32'h1);
      acc(1, 16'h604A, 8'h02, 32'h0, 1);
      acc(1, 16'h604A, 8'h02, 32'hFFFF, 0);
      acc(1, 16'h604A, 8'h02, 32'h0001_0000, 1);
      chk(tm, 16'hFFFF);
      acc(0, 16'h1234, 8'h00, 32'h0, 1);
      $display("ranges done");
    end
  endtask
  task tally_and_finish;
    begin
      $display("checks=%0d bad=%0d", check_count, bad_count);
      if (bad_count == 0 && check_count > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  initial begin
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    t_defaults;
    t_qs_codes;
    t_shut_dis;
    t_ranges;
    tally_and_finish;
  end
  // Whole run is about a hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    bad_count = bad_count + 1;
    tally_and_finish;
  end
endmodule
